// ### shared/rtd_defines.svh
// Purpose: Offsets, field positions, reset values and limit codes of the RTD value formatter.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Limit codes are signed 16-bit words in range units.
`ifndef RTD_DEFINES_SVH
`define RTD_DEFINES_SVH

`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_MASK       8'h08
`define OFF_VALUE      8'h0C
`define OFF_DIAG       8'h10

`define CTRL_W         7
`define CTRL_RST       7'h10
`define STAT_W         4
`define STAT_OPEN      0
`define STAT_LOWER     1
`define STAT_UPPER     2
`define STAT_CONV      3
`define MASK_RST       4'h0

`define RES_CODE_MAX   3'h4
`define RES_BASE_BITS  11

`define SAT_HI         16'h7FFF
`define SAT_LO         16'h8000

`define PTS_RATED_HI   16'h2134
`define PTS_OVER_HI    16'h2710
`define PTS_RATED_LO   16'hF830
`define PTS_UNDER_LO   16'hF682
`define PTC_RATED_HI   16'h32C8
`define PTC_OVER_HI    16'h3C8C
`define PTC_RATED_LO   16'hD120
`define PTC_UNDER_LO   16'hC75C
`define NIS_RATED_HI   16'h09C4
`define NIS_OVER_HI    16'h0B86
`define NIS_RATED_LO   16'hFDA8
`define NIS_UNDER_LO   16'hFBE6

`define ERR_NONE       5'h00
`define ERR_OPEN       5'h06
`define ERR_UPPER      5'h07
`define ERR_LOWER      5'h08

`endif

// ### shared/rtd_pkg.sv
// Purpose: Types shared by the RTD value formatter and its helpers.
// Assumes: Field widths match the defines header.
// Notes:   Range codes follow the order of the enum.
package rtd_pkg;

  typedef enum logic [1:0] {
    platinum_standard_range,
    platinum_climatic_range,
    nickel_standard_range,
    range_unused
  } range_e;

  typedef enum logic [2:0] {
    band_rated,
    band_over,
    band_under,
    band_overflow,
    band_underflow
  } band_e;

  typedef struct packed {
    logic       ovf_en;
    logic       wb_en;
    logic [2:0] res;
    range_e     range;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] band;
    logic [4:0] code;
  } diag_s;

endpackage : rtd_pkg

// ### logic/rtd_input_sync.sv
// Purpose: Two-flop synchroniser for a level that arrives from a pin.
// Assumes: The level is slow against pclk.
// Notes:   Only the second flop is read outside.
`timescale 1ns/1ns
module rtd_input_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic pin_in,
  output logic      level_out
);

  logic meta_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff   <= 1'b0;
      level_out <= 1'b0;
    end
    else if (ce)
    begin
      meta_ff   <= pin_in;
      level_out <= meta_ff;
    end
  end

endmodule : rtd_input_sync

// ### logic/rtd_range_classifier.sv
// Purpose: Sorts a scaled reading into the bands of the selected sensor range.
// Assumes: The reading is already left-justified in the 16-bit word.
// Notes:   Purely combinational; the unused range code reports not valid.
`timescale 1ns/1ns
`include "rtd_defines.svh"
module rtd_range_classifier
  import rtd_pkg::*;
(
  input  wire logic [15:0] value,
  input  range_e           range_sel,
  output band_e            band,
  output logic             range_ok
);

  logic signed [15:0] rated_hi;
  logic signed [15:0] over_hi;
  logic signed [15:0] rated_lo;
  logic signed [15:0] under_lo;
  logic signed [15:0] sval;

  assign sval     = $signed(value);
  assign range_ok = (range_sel != range_unused);
  assign rated_hi = $signed((range_sel == platinum_climatic_range) ? `PTC_RATED_HI :
                            (range_sel == nickel_standard_range)   ? `NIS_RATED_HI : `PTS_RATED_HI);
  assign over_hi  = $signed((range_sel == platinum_climatic_range) ? `PTC_OVER_HI :
                            (range_sel == nickel_standard_range)   ? `NIS_OVER_HI : `PTS_OVER_HI);
  assign rated_lo = $signed((range_sel == platinum_climatic_range) ? `PTC_RATED_LO :
                            (range_sel == nickel_standard_range)   ? `NIS_RATED_LO : `PTS_RATED_LO);
  assign under_lo = $signed((range_sel == platinum_climatic_range) ? `PTC_UNDER_LO :
                            (range_sel == nickel_standard_range)   ? `NIS_UNDER_LO : `PTS_UNDER_LO);

  assign band = (sval > over_hi)  ? band_overflow :
                (sval > rated_hi) ? band_over :
                (sval < under_lo) ? band_underflow :
                (sval < rated_lo) ? band_under : band_rated;

endmodule : rtd_range_classifier

// ### logic/rtd_value_formatter.sv
// Purpose: Formats converter readings into the 16-bit accumulator word with range
//          classification, saturation, wire-break substitution and diagnostics.
// Assumes: conv_valid and conv_code come from converter logic on pclk; the wire
//          break flag comes from a pin; registers are reached over APB.
// Notes:   Zero-wait APB slave; one level interrupt from sticky status bits.
// Operation
// - Word is 16-bit two's complement, sign in bit 15.
// - Two's complement; same nominal range gives same code for input and output.
// - Lower resolutions are left-justified, unused low bits forced to zero.
// - LSB weight is 16, 8, 4, 2, 1 for 11 to 15 bits plus sign.
// - Wire break with break diagnostics on gives 7FFF and open-circuit event.
// - Break diagnostics off, limit diagnostics on: 8000 and lower-limit event.
// - Both diagnostics off: wire break gives 8000 and no event.
// - Platinum standard: tenth degree units, rated -2000 to 8500.
// - Platinum standard overshoot to 10000, underrange to -2430, then saturation.
// - Platinum climatic: hundredth degree, rated -12000..13000, limits 15500/-14500.
// - Nickel standard: tenth degree, nominal -600..2500, limits 2950/-1050.
// - Classify into five bands; overshoot and underrange pass unchanged.
// - Output 7FFF until first conversion after reset or parameter change.
// - Lower-limit event uses error code 8.
// - Open-circuit event uses error code 6.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "rtd_defines.svh"
module rtd_value_formatter
  import rtd_pkg::*;
#(
  parameter int WORD_W = 16
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_valid,
  input  wire logic [15:0] conv_code,
  input  wire logic        wire_break_pin,
  output logic      [15:0] accumulator_word,
  output logic             word_fresh,
  output logic             irq
);

  typedef enum logic {
    fmt_stale,
    fmt_live
  } fmt_e;

  if (WORD_W != 16)
  begin : g_width_check
    $error("rtd_value_formatter serves a 16-bit word only");
  end

  // Shift that left-justifies a reading of the given resolution code.
  function automatic logic [3:0] justify_shift(input logic [2:0] res);
    logic [3:0] sh;
    sh = 4'h4 - {1'b0, res};
    return sh;
  endfunction : justify_shift

  ctrl_s              ctrl_ff;
  logic [`STAT_W-1:0] status_ff;
  logic [`STAT_W-1:0] mask_ff;
  diag_s              diag_ff;
  fmt_e               fmt_ff;
  logic [15:0]        word_ff;
  logic [31:0]        prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;
  logic               irq_ff;

  logic               wire_break;
  logic               setup;
  logic               access;
  logic               wr_access;
  logic               hit_ctrl;
  logic               hit_status;
  logic               hit_mask;
  logic               hit_value;
  logic               hit_diag;
  logic               hit_any;
  logic               res_ok;
  logic               range_ok;
  logic               cfg_ok;
  logic [15:0]        scaled;
  band_e              band;
  logic               take;
  logic               ev_open;
  logic               ev_lower;
  logic               ev_upper;
  logic [`STAT_W-1:0] events;
  logic [`STAT_W-1:0] clr;
  logic [15:0]        nxt_word;
  logic [4:0]         nxt_code;
  logic [`STAT_W-1:0] nxt_status;
  logic [31:0]        nxt_prdata;

  rtd_input_sync u_break_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .pin_in    (wire_break_pin),
    .level_out (wire_break)
  );

  // Readings are scaled before classification so the limits apply to the word.
  assign res_ok = (ctrl_ff.res <= `RES_CODE_MAX);
  assign scaled = conv_code << justify_shift(ctrl_ff.res);

  rtd_range_classifier u_classifier
  (
    .value     (scaled),
    .range_sel (ctrl_ff.range),
    .band      (band),
    .range_ok  (range_ok)
  );

  assign cfg_ok = res_ok & range_ok;

  assign setup      = psel & ~penable;
  assign access     = psel & penable & pready_ff;
  assign wr_access  = access & pwrite & ~pslverr_ff;
  assign hit_ctrl   = (paddr == `OFF_CTRL);
  assign hit_status = (paddr == `OFF_STATUS);
  assign hit_mask   = (paddr == `OFF_MASK);
  assign hit_value  = (paddr == `OFF_VALUE);
  assign hit_diag   = (paddr == `OFF_DIAG);
  assign hit_any    = hit_ctrl | hit_status | hit_mask | hit_value | hit_diag;

  assign nxt_prdata = hit_ctrl   ? {25'h0, ctrl_ff} :
                      hit_status ? {28'h0, status_ff} :
                      hit_mask   ? {28'h0, mask_ff} :
                      hit_value  ? {15'h0, (fmt_ff == fmt_live), word_ff} :
                      hit_diag   ? {24'h0, diag_ff} : 32'h0;

  // A parameter write takes priority over a conversion landing in the same cycle.
  assign take = conv_valid & ~(wr_access & hit_ctrl);

  // Invalid settings first, then wire break, then saturation bands, then the measured value.
  assign ev_open  = take & cfg_ok & wire_break & ctrl_ff.wb_en;
  assign ev_lower = take & cfg_ok & ctrl_ff.ovf_en & ~(wire_break & ctrl_ff.wb_en) &
                    (wire_break | (band == band_underflow));
  assign ev_upper = take & cfg_ok & ctrl_ff.ovf_en & ~wire_break & (band == band_overflow);
  assign events   = {take & cfg_ok, ev_upper, ev_lower, ev_open};

  assign nxt_word = ~cfg_ok                        ? `SAT_HI :
                    (wire_break & ctrl_ff.wb_en)   ? `SAT_HI :
                    wire_break                     ? `SAT_LO :
                    (band == band_overflow)        ? `SAT_HI :
                    (band == band_underflow)       ? `SAT_LO : scaled;

  assign nxt_code = ev_open  ? `ERR_OPEN :
                    ev_lower ? `ERR_LOWER :
                    ev_upper ? `ERR_UPPER : `ERR_NONE;

  // Set wins over a write-one-to-clear in the same cycle.
  assign clr        = (wr_access & hit_status) ? pwdata[`STAT_W-1:0] : '0;
  assign nxt_status = (status_ff & ~clr) | events;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else if (ce)
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit_any;
      if (setup)
      begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= ctrl_s'(`CTRL_RST);
      mask_ff <= `MASK_RST;
    end
    else if (ce & wr_access)
    begin
      if (hit_ctrl)
      begin
        ctrl_ff <= ctrl_s'(pwdata[`CTRL_W-1:0]);
      end
      if (hit_mask)
      begin
        mask_ff <= pwdata[`STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= '0;
      irq_ff    <= 1'b0;
    end
    else if (ce)
    begin
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & mask_ff);
    end
  end

  // The word is only replaced whole, so a reader never sees a mixed value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_ff  <= fmt_stale;
      word_ff <= `SAT_HI;
      diag_ff <= '0;
    end
    else if (ce)
    begin
      unique case (fmt_ff)
        fmt_stale:
        begin
          if (take & cfg_ok)
          begin
            fmt_ff <= fmt_live;
          end
        end
        fmt_live:
        begin
          if (wr_access & hit_ctrl)
          begin
            fmt_ff <= fmt_stale;
          end
        end
      endcase
      if (wr_access & hit_ctrl)
      begin
        word_ff <= `SAT_HI;
      end
      else if (take)
      begin
        word_ff <= nxt_word;
        diag_ff <= '{band: band, code: nxt_code};
      end
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign accumulator_word = word_ff;
  assign word_fresh       = (fmt_ff == fmt_live);
  assign irq              = irq_ff;

endmodule : rtd_value_formatter

// ### testbench/rtd_conv_source.sv
// Purpose: Converter-side source that hands one reading to the formatter per request.
// Assumes: fire is a one-cycle request on pclk.
// Notes:   Between pulses the code lines invert every cycle, alternating between the last code and its inverse.
`timescale 1ns/1ns
module rtd_conv_source
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [15:0] code_in,
  output logic             conv_valid,
  output logic      [15:0] conv_code
);
  // A stale code would hide a formatter that samples outside the pulse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_valid <= 1'b0;
      conv_code  <= 16'h0000;
    end
    else
    begin
      conv_valid <= fire;
      conv_code  <= fire ? code_in : ~conv_code;
    end
  end
endmodule : rtd_conv_source

// ### testbench/rtd_value_formatter_monitor.sv
// Purpose: Port-level checks of the formatter's bus answer and word handling.
// Assumes: Zero-wait APB answer; CTRL at offset 0.
// Notes:   Bound to every formatter instance.
`timescale 1ns/1ns
module rtd_value_formatter_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_valid,
  input wire logic [15:0] accumulator_word,
  input wire logic        word_fresh
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_ctrl_wr; psel && penable && pwrite && pready && ce && paddr == 8'h00; endsequence
  property p_ready_one; s_setup |=> pready; endproperty
  property p_ready_pulse; pready && ce |=> !pready; endproperty
  property p_err_unmapped; pready && paddr > 8'h10 |-> pslverr; endproperty
  property p_err_mapped; pready && paddr <= 8'h10 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  property p_marker; !word_fresh |-> accumulator_word == 16'h7FFF; endproperty
  property p_fresh_cause; $rose(word_fresh) |-> $past(conv_valid && ce); endproperty
  property p_word_hold; $changed(accumulator_word) |-> $past(conv_valid) || $past(pwrite && penable); endproperty
  property p_ctrl_restart; s_ctrl_wr |=> !word_fresh && accumulator_word == 16'h7FFF; endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("no access answer after setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped offset not refused");
  a_err_mapped: assert property (p_err_mapped)
    else $error("mapped offset refused");
  a_marker: assert property (p_marker)
    else $error("word not 7FFF before first conversion");
  a_fresh_cause: assert property (p_fresh_cause)
    else $error("fresh without conversion");
  a_word_hold: assert property (p_word_hold)
    else $error("word changed between conversions");
  a_ctrl_restart: assert property (p_ctrl_restart)
    else $error("word not restored after parameter write");
endmodule : rtd_value_formatter_monitor

bind rtd_value_formatter rtd_value_formatter_monitor rtd_value_formatter_monitor_inst (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .accumulator_word(accumulator_word),
  .word_fresh(word_fresh));

// ### testbench/rtd_value_formatter_bench.sv
// Purpose: Drives readings through every range, resolution codes 0, 2 and 4, and every wire-break case.
// Assumes: Zero-wait APB slave, all status bits unmasked in the table pass.
// Notes:   Table row: ctrl, code, word, wire break and events, error code.
`timescale 1ns/1ns
`include "rtd_defines.svh"
module rtd_value_formatter_bench;
  logic        pclk, presetn, ce, psel, penable, pwrite, fire, wb_pin, rerr;
  logic        pready, pslverr, conv_valid, word_fresh, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] fire_code, conv_code, accumulator_word;
  int          fails, samples_checked;
  logic [47:0] tv [12] = '{48'h10_2134_2134_00, 48'h10_2710_2710_00, 48'h10_2711_7FFF_00,
    48'h10_F681_8000_00, 48'h51_C75B_8000_28, 48'h51_3C8D_7FFF_47, 48'h02_009C_09C0_00,
    48'h0A_02E1_0B84_00, 48'h12_FDA7_FDA7_00, 48'h30_0000_7FFF_96, 48'h50_0000_8000_A8,
    48'h10_0000_8000_80};
  rtd_value_formatter rtd_value_formatter_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_valid(conv_valid), .conv_code(conv_code), .wire_break_pin(wb_pin),
    .accumulator_word(accumulator_word), .word_fresh(word_fresh), .irq(irq));
  rtd_conv_source rtd_conv_source_inst (.pclk(pclk), .presetn(presetn), .fire(fire), .code_in(fire_code),
    .conv_valid(conv_valid), .conv_code(conv_code));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    chk(n, 32'h1);
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic convert(input logic [15:0] c);
    fire_code <= c;
    fire      <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : convert
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (4000) @(posedge pclk);
    fails++;
    results();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, fire, wb_pin} = 6'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire_code = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`OFF_CTRL, 1'b0, 32'h0);
    chk(rdata, 32'h10);
    apb(`OFF_VALUE, 1'b0, 32'h0);
    chk(rdata, 32'h7FFF);
    apb(8'h20, 1'b0, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(`OFF_MASK, 1'b1, 32'hF);
    apb(`OFF_MASK, 1'b0, 32'h0);
    chk(rdata, 32'hF);
    foreach (tv[i])
    begin
      wb_pin <= tv[i][7];
      apb(`OFF_CTRL, 1'b1, {24'h0, tv[i][47:40]});
      repeat (3) @(posedge pclk);
      chk({16'h0, accumulator_word}, 32'h7FFF);
      convert(tv[i][39:24]);
      chk({16'h0, accumulator_word}, {16'h0, tv[i][23:8]});
      chk({31'h0, word_fresh}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(`OFF_STATUS, 1'b0, 32'h0);
      chk(rdata, {28'h0, 1'b1, tv[i][6:4]});
      if (tv[i][3:0] != 4'h0)
      begin
        apb(`OFF_DIAG, 1'b0, 32'h0);
        chk({27'h0, rdata[4:0]}, {28'h0, tv[i][3:0]});
      end
      apb(`OFF_STATUS, 1'b1, 32'hF);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    wb_pin <= 1'b0;
    apb(`OFF_MASK, 1'b1, 32'h0);
    convert(16'h0100);
    chk({31'h0, irq}, 32'h0);
    apb(`OFF_STATUS, 1'b0, 32'h0);
    chk(rdata, 32'h8);
    chk({16'h0, accumulator_word}, 32'h0100);
    ce <= 1'b0;
    convert(16'h0200);
    chk({16'h0, accumulator_word}, 32'h0100);
    ce      <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({15'h0, word_fresh, accumulator_word}, 32'h7FFF);
    convert(16'h0100);
    chk({15'h0, word_fresh, accumulator_word}, 32'h10100);
    results();
  end
endmodule : rtd_value_formatter_bench
